//--- inc/charge_seq_pkg.sv
// constants shared by the charge sequencer, its phase timer and the bench.
// assumes a 250 MHz ref_clk and voltage codes in millivolts.
package charge_seq_pkg;
  // clock and oscillator tick timing
  localparam int CLK_PERIOD_NS   = 4;          // ref_clk period
  localparam int OSC_TICK_NS     = 1000000;    // stand-in oscillator period, 1 ms
  localparam int OSC_TICK_CYCLES = (OSC_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_HALF_MS   = 500;        // indicator blink half period
  localparam int BLINK_TICKS     = BLINK_HALF_MS * 1000000 / OSC_TICK_NS;

  // voltage and temperature codes, millivolt units
  localparam int MV_W = 14;
  localparam logic [MV_W-1:0] DEEP_DISCHARGE_MV = 14'h07D0;  // 2.0 V
  localparam logic [MV_W-1:0] UNDERVOLTAGE_MV   = 14'h08FC;  // 2.3 V
  localparam logic [MV_W-1:0] PRECHARGE_MV      = 14'h0B54;  // 2.9 V
  localparam logic [MV_W-1:0] RECHARGE_MV       = 14'h0F3C;  // 3.9 V
  localparam logic [MV_W-1:0] OVERVOLTAGE_MV    = 14'h10FE;  // 4.35 V
  localparam logic [MV_W-1:0] COLD_LIMIT_MV     = 14'h035C;  // 0.860 V, about 3 C
  localparam logic [MV_W-1:0] HOT_START_MV      = 14'h019D;  // 0.413 V, about 43 C
  localparam logic [MV_W-1:0] HOT_RUN_MV        = 14'h0161;  // 0.353 V, about 50 C

  // register byte offsets
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] STATUS_OFS     = 8'h04;
  localparam logic [7:0] INT_STATUS_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS   = 8'h0C;
  localparam logic [7:0] RECON_LIM_OFS  = 8'h10;
  localparam logic [7:0] PRE_LIM_OFS    = 8'h14;
  localparam logic [7:0] TOTAL_LIM_OFS  = 8'h18;

  // control fields
  localparam int CTRL_TWO_CELL_BIT = 0;
  localparam int CTRL_RESTART_BIT  = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // event bits of interrupt status and mask
  localparam int EV_W       = 5;
  localparam int EV_START   = 0;
  localparam int EV_FULL    = 1;
  localparam int EV_TIMEOUT = 2;
  localparam int EV_TEMP    = 3;
  localparam int EV_RECHG   = 4;
  localparam logic [EV_W-1:0] INT_MASK_RESET = 5'h00;

  // phase timer terminal counts in oscillator ticks
  localparam logic [31:0] RECON_LIM_RESET = 32'h001B_7740;  // 30 min
  localparam logic [31:0] PRE_LIM_RESET   = 32'h001B_7740;  // 30 min
  localparam logic [31:0] TOTAL_LIM_RESET = 32'h00A4_CB80;  // 3 h

  // charge current selection
  localparam logic [1:0] CUR_OFF   = 2'h0;
  localparam logic [1:0] CUR_RECON = 2'h1;  // small fixed current
  localparam logic [1:0] CUR_PRE   = 2'h2;  // about one eighth of high rate
  localparam logic [1:0] CUR_HIGH  = 2'h3;

  // charger states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE    = 7'b000_0001,
    ST_RECON   = 7'b000_0010,
    ST_PRECHG  = 7'b000_0100,
    ST_FAST    = 7'b000_1000,
    ST_DONE    = 7'b001_0000,
    ST_TIMEOUT = 7'b010_0000,
    ST_FAULT   = 7'b100_0000
  } charge_state_t;
endpackage

//--- inc/phase_timer_if.sv
// bundle between the sequencer and its phase timer.
// assumes both ends share ref_clk.
`timescale 1ns/100ps
interface phase_timer_if;
  logic        start;    // restart count, one cycle
  logic        run;      // count while high
  logic        tick;     // oscillator tick, one cycle
  logic [31:0] limit;    // terminal count in ticks
  logic        expired;  // level, terminal count reached
  modport ctrl (output start, output run, output tick, output limit, input expired);
  modport tmr  (input start, input run, input tick, input limit, output expired);
endinterface // phase_timer_if

//--- logic/phase_timer.sv
// phase timer: counts oscillator ticks from a restart up to a terminal count.
// assumes start is a one-cycle pulse on each phase entry.
`timescale 1ns/100ps
module phase_timer (
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  phase_timer_if.tmr tif
);
  import charge_seq_pkg::*;

  logic [31:0] count_ff;    // ticks since phase entry
  logic        expired_ff;  // held until the next restart

  // tick counter, cleared on every restart
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_ff <= 32'h0000_0000;
    end else if (tif.start) begin
      count_ff <= 32'h0000_0000;
    end else if (tif.run && tif.tick && !expired_ff) begin
      count_ff <= count_ff + 32'h0000_0001;
    end
  end

  // expiry flag; stays set so a late check still sees it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      expired_ff <= 1'b0;
    end else if (tif.start) begin
      expired_ff <= 1'b0;
    end else if (tif.run && count_ff >= tif.limit) begin
      expired_ff <= 1'b1;
    end
  end

  assign tif.expired = expired_ff;
endmodule // phase_timer

//--- logic/li_ion_charge_sequencer.sv
// charge sequencer for a one- or two-cell lithium charger, with wishbone registers.
// assumes comparator bits from the analog front end and millivolt codes from a
// converter running on ref_clk; current and voltage regulation live outside.
// Summary of operation
// - start needs adaptor good and cell below overvoltage
// - start needs reset, on/off low, temperature inside
// - decisions use pack voltage divided by cells
// - below deep-discharge, recondition and start timer
// - reconditioning timeout latches until reset or repower
// - pre-charge at eighth current until threshold
// - pre-charge timeout latches terminated, same restart
// - high rate until overvoltage or low current
// - total charge timer expiry terminates charging
// - above overvoltage, charge current fully off
// - recharge at recharge threshold, repeat while connected
// - temperature or phase timer terminates immediately
// - lower hot limit at start, higher while charging
// - indicators follow state, blink or steady
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module li_ion_charge_sequencer #(
  parameter int TICK_CYCLES = charge_seq_pkg::OSC_TICK_CYCLES,  // ref_clk cycles per tick
  parameter int BLINK_LEN   = charge_seq_pkg::BLINK_TICKS       // ticks per blink half
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  // wishbone classic slave
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [7:0]                      wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  // analog front end
  input  wire logic                            adaptorGood,
  input  wire logic                            currentLow,
  input  wire logic                            resetPin,
  input  wire logic                            onOffPin,
  input  wire logic [charge_seq_pkg::MV_W-1:0] packMv,
  input  wire logic [charge_seq_pkg::MV_W-1:0] tempMv,
  // outputs
  output logic      [1:0]                      chargeCurrent,
  output logic                                 redIndicator,
  output logic                                 greenIndicator,
  output logic                                 chargingTestOutput,
  output logic                                 doneTestOutput,
  output logic                                 irq
);
  import charge_seq_pkg::*;

  // ---------------- synchronisers ----------------
  logic [3:0]  syncA_ff;        // first stage, read only by the second
  logic [3:0]  syncB_ff;        // second stage, used by the logic
  logic        adpOk;           // adaptor above high threshold
  logic        curLow;          // charge current below full-charge level
  logic        rstHigh;         // reset pin high
  logic        offHigh;         // on/off pin high

  // two flops per comparator bit so no decision sees a metastable value
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syncA_ff <= 4'h0;
      syncB_ff <= 4'h0;
    end else begin
      syncA_ff <= {onOffPin, resetPin, currentLow, adaptorGood};
      syncB_ff <= syncA_ff;
    end
  end

  assign adpOk   = syncB_ff[0];
  assign curLow  = syncB_ff[1];
  assign rstHigh = syncB_ff[2];
  assign offHigh = syncB_ff[3];

  // ---------------- registers ----------------
  logic [31:0]     ctrl_ff;      // cell count select
  logic [EV_W-1:0] intStat_ff;   // sticky events
  logic [EV_W-1:0] intMask_ff;   // event enables
  logic [31:0]     reconLim_ff;  // reconditioning terminal count
  logic [31:0]     preLim_ff;    // pre-charge terminal count
  logic [31:0]     totalLim_ff;  // total charge terminal count
  logic            ack_ff;       // wishbone acknowledge
  logic [31:0]     rdat_ff;      // registered read data
  logic            wrNow;        // write takes effect this edge
  logic            restartReq;   // software restart, one cycle
  logic [EV_W-1:0] events;       // event pulses from the sequencer
  logic [31:0]     rdMux;        // read data selection
  logic [31:0]     wmask;        // byte lane mask
  charge_state_t   state_ff;

  // byte enables become a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // write lands at the edge where the master samples ack
  assign wrNow      = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  assign restartReq = wrNow && (wb_adr_i == CTRL_OFS) && wb_sel_i[0]
                      && wb_dat_i[CTRL_RESTART_BIT];

  // one wait state, ack for one cycle; unmapped reads give zero and are still acked
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end

  // read selection
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (wb_adr_i)
      CTRL_OFS:       rdMux = {31'h0000_0000, ctrl_ff[CTRL_TWO_CELL_BIT]};
      STATUS_OFS:     rdMux = {20'h0_0000, redIndicator, greenIndicator,
                               chargeCurrent, 1'b0, state_ff};
      INT_STATUS_OFS: rdMux = {27'h000_0000, intStat_ff};
      INT_MASK_OFS:   rdMux = {27'h000_0000, intMask_ff};
      RECON_LIM_OFS:  rdMux = reconLim_ff;
      PRE_LIM_OFS:    rdMux = preLim_ff;
      TOTAL_LIM_OFS:  rdMux = totalLim_ff;
      default:        rdMux = 32'h0000_0000;  // unmapped
    endcase
  end

  // read data captured with ack
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdat_ff <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      rdat_ff <= rdMux;
    end
  end

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;

  // control and limit registers; restart bit is self-clearing
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_ff     <= CTRL_RESET;
      reconLim_ff <= RECON_LIM_RESET;
      preLim_ff   <= PRE_LIM_RESET;
      totalLim_ff <= TOTAL_LIM_RESET;
    end else if (wrNow) begin
      unique case (wb_adr_i)
        CTRL_OFS: begin
          ctrl_ff[CTRL_TWO_CELL_BIT] <= wb_sel_i[0] ? wb_dat_i[CTRL_TWO_CELL_BIT]
                                                    : ctrl_ff[CTRL_TWO_CELL_BIT];
        end
        RECON_LIM_OFS: reconLim_ff <= (reconLim_ff & ~wmask) | (wb_dat_i & wmask);
        PRE_LIM_OFS:   preLim_ff   <= (preLim_ff & ~wmask) | (wb_dat_i & wmask);
        TOTAL_LIM_OFS: totalLim_ff <= (totalLim_ff & ~wmask) | (wb_dat_i & wmask);
        default: begin
        end
      endcase
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      intMask_ff <= INT_MASK_RESET;
    end else if (wrNow && wb_adr_i == INT_MASK_OFS && wb_sel_i[0]) begin
      intMask_ff <= wb_dat_i[EV_W-1:0];
    end
  end

  // sticky status, write one to clear; a same-cycle event wins over the clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      intStat_ff <= {EV_W{1'b0}};
    end else if (wrNow && wb_adr_i == INT_STATUS_OFS && wb_sel_i[0]) begin
      intStat_ff <= (intStat_ff & ~wb_dat_i[EV_W-1:0]) | events;
    end else begin
      intStat_ff <= intStat_ff | events;
    end
  end

  assign irq = |(intStat_ff & intMask_ff);

  // ---------------- oscillator tick and blink ----------------
  logic [31:0] prescale_ff;   // ref_clk cycles within a tick
  logic        tick;          // one cycle per oscillator period
  logic [31:0] blinkCnt_ff;   // ticks within a blink half
  logic        blink_ff;      // blink phase

  // tick divider stands in for the rc oscillator
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prescale_ff <= 32'h0000_0000;
    end else if (tick) begin
      prescale_ff <= 32'h0000_0000;
    end else begin
      prescale_ff <= prescale_ff + 32'h0000_0001;
    end
  end

  assign tick = (prescale_ff == 32'(TICK_CYCLES - 1));

  // blink phase toggles every half period
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      blinkCnt_ff <= 32'h0000_0000;
      blink_ff    <= 1'b0;
    end else if (tick) begin
      if (blinkCnt_ff == 32'(BLINK_LEN - 1)) begin
        blinkCnt_ff <= 32'h0000_0000;
        blink_ff    <= !blink_ff;
      end else begin
        blinkCnt_ff <= blinkCnt_ff + 32'h0000_0001;
      end
    end
  end

  // ---------------- per-cell voltage and qualifiers ----------------
  logic [MV_W-1:0] cellMv;     // per-cell voltage
  logic            tempOk;     // temperature inside the window
  logic [MV_W-1:0] hotLimit;   // hot threshold for the present phase
  logic            charging;   // a charge phase is active
  logic            startOk;    // all start conditions hold

  // pack voltage shared evenly; two cells is a halving
  assign cellMv = ctrl_ff[CTRL_TWO_CELL_BIT] ? {1'b0, packMv[MV_W-1:1]} : packMv;

  assign charging = (state_ff == ST_RECON) || (state_ff == ST_PRECHG)
                    || (state_ff == ST_FAST);
  // sensor voltage falls as the pack warms
  assign hotLimit = charging ? HOT_RUN_MV : HOT_START_MV;
  assign tempOk   = (tempMv < COLD_LIMIT_MV) && (tempMv > hotLimit);
  assign startOk  = adpOk && (cellMv < OVERVOLTAGE_MV)
                    && !rstHigh && !offHigh && tempOk;

  // ---------------- sequencer ----------------
  charge_state_t nxt_state;
  phase_timer_if tif ();

  // next state and event pulses
  always_comb begin
    nxt_state = state_ff;
    events    = {EV_W{1'b0}};
    unique case (state_ff)
      ST_IDLE: begin
        if (startOk) begin
          events[EV_START] = 1'b1;
          if (cellMv < DEEP_DISCHARGE_MV) begin
            nxt_state = ST_RECON;
          end else if (cellMv < PRECHARGE_MV) begin
            nxt_state = ST_PRECHG;
          end else begin
            nxt_state = ST_FAST;
          end
        end
      end
      ST_RECON, ST_PRECHG, ST_FAST: begin
        if (!adpOk || rstHigh || offHigh || restartReq) begin
          nxt_state = ST_IDLE;  // charging stopped from outside
        end else if (!tempOk) begin
          nxt_state = ST_FAULT;
          events[EV_TEMP] = 1'b1;
        end else if (state_ff == ST_RECON && cellMv >= UNDERVOLTAGE_MV) begin
          nxt_state = (cellMv >= PRECHARGE_MV) ? ST_FAST : ST_PRECHG;
        end else if (state_ff == ST_PRECHG && cellMv >= PRECHARGE_MV) begin
          nxt_state = ST_FAST;
        end else if (state_ff == ST_FAST && (cellMv >= OVERVOLTAGE_MV || curLow)) begin
          nxt_state = ST_DONE;
          events[EV_FULL] = 1'b1;
        end else if (tif.expired) begin
          // recon, pre-charge or total timer ran out: latch terminated
          nxt_state = ST_TIMEOUT;
          events[EV_TIMEOUT] = 1'b1;
        end
      end
      ST_DONE: begin
        if (!adpOk || rstHigh || offHigh || restartReq) begin
          nxt_state = ST_IDLE;
        end else if (cellMv <= RECHARGE_MV && tempOk) begin
          nxt_state = ST_FAST;
          events[EV_RECHG] = 1'b1;
        end
      end
      ST_TIMEOUT: begin
        // held until a reset pulse, loss of input power, or software restart
        if (rstHigh || !adpOk || restartReq) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_FAULT: begin
        if (!adpOk || rstHigh || offHigh || restartReq) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;  // illegal code recovers
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // timer restarts on every phase entry and uses that phase's limit
  assign tif.start = (nxt_state != state_ff);
  assign tif.run   = charging;
  assign tif.tick  = tick;
  always_comb begin
    tif.limit = totalLim_ff;
    if (state_ff == ST_RECON) begin
      tif.limit = reconLim_ff;
    end else if (state_ff == ST_PRECHG) begin
      tif.limit = preLim_ff;
    end
  end

  phase_timer u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tif     (tif)
  );

  // ---------------- outputs ----------------
  // current select is registered from the next state, indicators from the present state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chargeCurrent <= CUR_OFF;
    end else if (cellMv > OVERVOLTAGE_MV) begin
      chargeCurrent <= CUR_OFF;
    end else begin
      unique case (nxt_state)
        ST_RECON:  chargeCurrent <= CUR_RECON;
        ST_PRECHG: chargeCurrent <= CUR_PRE;
        ST_FAST:   chargeCurrent <= CUR_HIGH;
        default:   chargeCurrent <= CUR_OFF;
      endcase
    end
  end

  // red blinks in recon and timeout, steady in pre-charge and high rate; green blinks when done
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      redIndicator       <= 1'b0;
      greenIndicator     <= 1'b0;
      chargingTestOutput <= 1'b0;
      doneTestOutput     <= 1'b0;
    end else begin
      redIndicator <= ((state_ff == ST_RECON || state_ff == ST_TIMEOUT) && blink_ff)
                      || state_ff == ST_PRECHG || state_ff == ST_FAST;
      greenIndicator     <= (state_ff == ST_DONE) && blink_ff;
      chargingTestOutput <= charging;
      doneTestOutput     <= (state_ff == ST_DONE);
    end
  end
endmodule // li_ion_charge_sequencer

//--- verif/li_ion_charge_sequencer_props.sv
// assertions on the charge sequencer top-level ports.
// assumes a single ref_clk domain and a synchronous active-low reset.
`timescale 1ns/100ps
module li_ion_charge_sequencer_props (
  input wire logic                            ref_clk,
  input wire logic                            rst_n,
  input wire logic                            wb_cyc_i,
  input wire logic                            wb_stb_i,
  input wire logic                            wb_ack_o,
  input wire logic                            adaptorGood,
  input wire logic                            resetPin,
  input wire logic                            onOffPin,
  input wire logic [charge_seq_pkg::MV_W-1:0] packMv,
  input wire logic [charge_seq_pkg::MV_W-1:0] tempMv,
  input wire logic [1:0]                      chargeCurrent,
  input wire logic                            redIndicator,
  input wire logic                            greenIndicator,
  input wire logic                            chargingTestOutput,
  input wire logic                            doneTestOutput,
  input wire logic                            irq
);
  import charge_seq_pkg::*;
  // pack above 8701 mV: over the limit whatever the cell count
  localparam logic [MV_W-1:0] TWO_OV = 14'h21FD;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // repetitions of six leave room for the two-flop synchroniser and output register
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  AST_OV_CUT: assert property ((packMv > TWO_OV) [*3] |-> chargeCurrent == CUR_OFF)
    else $error("current on above overvoltage");
  AST_RST_PIN: assert property (resetPin [*6] |-> chargeCurrent == CUR_OFF && !chargingTestOutput)
    else $error("charging while reset pin high");
  AST_OFF_PIN: assert property (onOffPin [*6] |-> chargeCurrent == CUR_OFF)
    else $error("charging while switched off");
  AST_NO_ADAPTOR: assert property (!adaptorGood [*6] |-> !chargingTestOutput)
    else $error("charging without adaptor");
  AST_HOT: assert property ((tempMv < HOT_RUN_MV) [*6] |-> chargeCurrent == CUR_OFF)
    else $error("charging while too hot");
  AST_TEST_EXCL: assert property (!(chargingTestOutput && doneTestOutput))
    else $error("charging and done outputs together");
  AST_DONE_RED: assert property (doneTestOutput && $past(doneTestOutput) |-> !redIndicator)
    else $error("red lit when done");
  AST_CHG_GREEN: assert property (chargingTestOutput && $past(chargingTestOutput)
    |-> !greenIndicator)
    else $error("green lit while charging");
  // main scenarios reached
  cover property (chargingTestOutput && chargeCurrent == CUR_HIGH);
  cover property ($rose(doneTestOutput));
  cover property ($rose(irq));
endmodule // li_ion_charge_sequencer_props

bind li_ion_charge_sequencer li_ion_charge_sequencer_props i_props (
  .ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .adaptorGood, .resetPin, .onOffPin,
  .packMv, .tempMv, .chargeCurrent, .redIndicator, .greenIndicator, .chargingTestOutput,
  .doneTestOutput, .irq);

//--- verif/battery_model.sv
// partner: adaptor, pack, thermistor and the reset and on/off switches.
// assumes the bench calls set_env just after a rising edge of ref_clk.
`timescale 1ns/100ps
module battery_model (
  output logic                            adaptorGood,
  output logic                            currentLow,
  output logic                            resetPin,
  output logic                            onOffPin,
  output logic [charge_seq_pkg::MV_W-1:0] packMv,
  output logic [charge_seq_pkg::MV_W-1:0] tempMv
);
  import charge_seq_pkg::*;
  // adaptor absent at power-up so no start can slip in during reset
  initial begin
    adaptorGood = 1'b0;
    currentLow  = 1'b0;
    resetPin    = 1'b0;
    onOffPin    = 1'b0;
    packMv      = 14'h0BB8;
    tempMv      = 14'h0258;
  end
  // whole front-end state changes at once, as a real pack swap would
  task automatic set_env(input logic adp, low, rp, off, input logic [MV_W-1:0] mv, tm);
    adaptorGood <= adp;
    currentLow  <= low;
    resetPin    <= rp;
    onOffPin    <= off;
    packMv      <= mv;
    tempMv      <= tm;
  endtask
endmodule // battery_model

//--- verif/li_ion_charge_sequencer_test.sv
// self-checking bench: register bus tasks and charge sequences.
// assumes battery_model drives the front end and the props checker is bound.
`timescale 1ns/100ps
module li_ion_charge_sequencer_test;
  import charge_seq_pkg::*;
  localparam logic [MV_W-1:0] TOK  = 14'h0258; // 600 mV, temperature inside window
  localparam logic [MV_W-1:0] THOT = 14'h012C; // 300 mV, too hot
  logic            ref_clk = 1'b0;
  logic            rst_n   = 1'b0;
  logic            cyc     = 1'b0;
  logic            stb     = 1'b0;
  logic            we      = 1'b0;
  logic [7:0]      adr     = 8'h00;
  logic [31:0]     wdat    = 32'h0000_0000;
  logic [31:0]     rdat;
  logic [31:0]     dato;
  logic            ack, irq, redIndicator, greenIndicator, tChg, tDone;
  logic            adaptorGood, currentLow, resetPin, onOffPin;
  logic [1:0]      chargeCurrent;
  logic [MV_W-1:0] packMv, tempMv;
  int              n_errors    = 0;
  int              check_count = 0;
  int              cycles      = 0;

  // 250 MHz
  always #2 ref_clk = ~ref_clk;

  // short tick and blink so timeouts fit the run
  li_ion_charge_sequencer #(.TICK_CYCLES(4), .BLINK_LEN(2)) i_dut (
    .ref_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack), .adaptorGood,
    .currentLow, .resetPin, .onOffPin, .packMv, .tempMv, .chargeCurrent, .redIndicator,
    .greenIndicator, .chargingTestOutput(tChg), .doneTestOutput(tDone), .irq);

  battery_model i_batt (.adaptorGood, .currentLow, .resetPin, .onOffPin, .packMv, .tempMv);

  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; read data is taken at the ack edge only
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    rdat = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // polls status; bounded so a stuck state cannot hang
  task automatic wait_st(input logic [6:0] st);
    int n;
    n = 0;
    do begin
      wb(1'b0, STATUS_OFS, 32'h0000_0000);
      n++;
    end while (rdat[6:0] !== st && n < 60);
    chk(rdat[6:0], st);
  endtask

  // new front-end conditions, then time for the synchronisers
  task automatic env(input logic adp, low, rp, off, input logic [MV_W-1:0] mv, tm);
    @(posedge ref_clk);
    i_batt.set_env(adp, low, rp, off, mv, tm);
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic cur_is(input logic [1:0] c);
    wb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rdat[9:8], c);
  endtask

  task automatic tend(input string name);
    $display("test %s finished, errors so far %0d", name, n_errors);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, far above the run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, an unmapped hole, short phase limits
    wb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_0001);
    wb(1'b0, TOTAL_LIM_OFS, 32'h0000_0000);
    chk(rdat, TOTAL_LIM_RESET);
    wb(1'b0, INT_MASK_OFS, 32'h0000_0000);
    chk(rdat, 32'(INT_MASK_RESET));
    wb(1'b0, 8'h1C, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    wb(1'b1, RECON_LIM_OFS, 32'h0000_0005);
    wb(1'b1, PRE_LIM_OFS, 32'h0000_0005);
    wb(1'b0, PRE_LIM_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_0005);
    tend("registers");
    // single cell at 9.0 V must not start
    env(1'b1, 1'b0, 1'b0, 1'b0, 14'h2328, TOK);
    wb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_0001);
    tend("overvoltage start");
    // start straight into high rate, start event raises irq
    wb(1'b1, INT_MASK_OFS, 32'h0000_0001);
    env(1'b1, 1'b0, 1'b0, 1'b0, 14'h0BB8, TOK);
    wait_st(ST_FAST);
    cur_is(CUR_HIGH);
    chk({tChg, tDone, redIndicator, greenIndicator}, 4'hA);
    chk(irq, 1'b1);
    wb(1'b1, INT_STATUS_OFS, 32'h0000_001F);
    @(posedge ref_clk);
    chk(irq, 1'b0);
    tend("high rate");
    // full charge by low current, then self-discharge to recharge level
    env(1'b1, 1'b1, 1'b0, 1'b0, 14'h0FA0, TOK);
    wait_st(ST_DONE);
    cur_is(CUR_OFF);
    env(1'b1, 1'b0, 1'b0, 1'b0, RECHARGE_MV, TOK);
    wait_st(ST_FAST);
    tend("done and recharge");
    // hot pack stops charge, switch-off clears the fault
    env(1'b1, 1'b0, 1'b0, 1'b0, 14'h0BB8, THOT);
    wait_st(ST_FAULT);
    cur_is(CUR_OFF);
    env(1'b1, 1'b0, 1'b0, 1'b1, 14'h0BB8, TOK);
    wait_st(ST_IDLE);
    tend("temperature fault");
    // deep-discharged cell: reconditioning times out and latches
    env(1'b1, 1'b0, 1'b0, 1'b0, 14'h076C, TOK);
    wait_st(ST_RECON);
    cur_is(CUR_RECON);
    wait_st(ST_TIMEOUT);
    env(1'b1, 1'b0, 1'b0, 1'b0, 14'h09C4, TOK);
    wait_st(ST_TIMEOUT);
    env(1'b1, 1'b0, 1'b1, 1'b0, 14'h09C4, TOK);
    wait_st(ST_IDLE);
    // after the reset pulse a 2.5 V cell pre-charges and times out
    env(1'b1, 1'b0, 1'b0, 1'b0, 14'h09C4, TOK);
    wait_st(ST_PRECHG);
    cur_is(CUR_PRE);
    wait_st(ST_TIMEOUT);
    tend("reconditioning and pre-charge");
    // two cells: 6.0 V pack is 3.0 V per cell
    env(1'b0, 1'b0, 1'b0, 1'b0, 14'h1770, TOK);
    wait_st(ST_IDLE);
    wb(1'b1, CTRL_OFS, 32'h0000_0001);
    env(1'b1, 1'b0, 1'b0, 1'b0, 14'h1770, TOK);
    wait_st(ST_FAST);
    tend("two cells");
    test_done();
  end
endmodule // li_ion_charge_sequencer_test
